// >>> gate_drive_init_lockout_tb.sv
// gate drive init lockout: self-checking bench for both ends
`timescale 1ns/10ps
`default_nettype none
module gate_drive_init_lockout_tb;
	logic clk, rstn, ce, pump_cfg, init_req, recover_req; // clock, reset, requests
	logic [7:0] fault_evt, mask_value; // fault pulses, irq mask
	logic [4:0] mode_value; // mode bits
	logic [3:0] dead_value; // deadtime steps
	logic [2:0] ls_req, hs_n_req; // run-time phase levels
	logic [2:0] hi, lo, sh, hi2, lo2, sh2; // gates of both drivers
	logic pump_run, ready, running, idle, stat_valid; // flags
	logic [7:0] stat_one, stat_two; // captured status words
	int num_errors, n_tests; // verdict counters
	gdil_if link (); // controller-driver link
	gdil_if solo (); // second driver, pins from the bench
	gdil_dev_end #(.PU_CYCLES(20)) gdil_dev_end_i (.clk(clk), .rstn(rstn), .ce(ce), .bus(link),
		.fault_evt(fault_evt), .pump_cfg(pump_cfg), .high_gate_output(hi), .low_gate_output(lo),
		.high_gate_short(sh), .pump_run(pump_run), .ready(ready));
	// second driver takes deliberately misordered edges
	gdil_dev_end #(.PU_CYCLES(20)) gdil_dev_end_solo_i (.clk(clk), .rstn(rstn), .ce(ce),
		.bus(solo), .fault_evt(8'h00), .pump_cfg(pump_cfg), .high_gate_output(hi2),
		.low_gate_output(lo2), .high_gate_short(sh2), .pump_run(), .ready());
	gdil_ctl_end #(.PU_CYCLES(20)) gdil_ctl_end_i (.clk(clk), .rstn(rstn), .ce(ce), .bus(link),
		.init_req(init_req), .recover_req(recover_req), .mask_value(mask_value),
		.mode_value(mode_value), .dead_value(dead_value), .phase_ls_req(ls_req),
		.phase_hs_n_req(hs_n_req), .running(running), .idle(idle), .stat_one(stat_one),
		.stat_two(stat_two), .stat_valid(stat_valid));
	gdil_link_monitor #(.DT_CYC(20)) gdil_link_monitor_i (.clk(clk), .rstn(rstn),
		.gate_enable_one(link.gate_enable_one), .gate_enable_two(link.gate_enable_two),
		.phase_low_side_in(link.phase_low_side_in),
		.phase_high_side_in_n(link.phase_high_side_in_n), .sclk(link.sclk), .cs_n(link.cs_n),
		.irq(link.irq));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait on idle (0), running (1) or the status pulse (2); a miss counts
	task automatic await(input int sel);
		int i;
		logic f;
		i = 0;
		f = 1'b0;
		while (f !== 1'b1 && i < 6000) begin
			@(negedge clk);
			f = (sel == 0) ? idle : ((sel == 1) ? running : stat_valid);
			i++;
		end
		if (f !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, f, 1'b1);
		end
	endtask
	task automatic settle_run;
		repeat (4) @(negedge clk);
		await(1);
		repeat (8) @(negedge clk);
	endtask
	task automatic t_init(input logic [4:0] mode);
		@(posedge clk);
		mode_value <= mode;
		init_req <= 1'b1;
		@(posedge clk);
		init_req <= 1'b0;
		settle_run();
		chk({5'h00, sh}, 8'h07);
		chk({2'h0, hi, lo}, 8'h00);
	endtask
	// run-time control, then a fault while a high side is on
	task automatic t_fault(input logic [7:0] evt, input logic [4:0] exp_mode);
		@(posedge clk);
		hs_n_req <= 3'h3;
		repeat (10) @(negedge clk);
		chk({5'h00, hi}, 8'h04);
		@(posedge clk);
		fault_evt <= evt;
		@(posedge clk);
		fault_evt <= 8'h00;
		repeat (3) @(negedge clk);
		chk({2'h0, hi, lo}, 8'h00);
		chk({5'h00, sh}, 8'h00);
		await(2);
		chk(stat_one, evt);
		chk({stat_two[7:2], 2'h0}, {1'b1, exp_mode, 2'h0});
		@(posedge clk);
		hs_n_req <= 3'h7;
		settle_run();
		chk({5'h00, sh}, 8'h07);
	endtask
	// masked source: shutdown but no interrupt, host recovers by request
	task automatic t_mask;
		@(posedge clk);
		fault_evt <= 8'h20;
		@(posedge clk);
		fault_evt <= 8'h00;
		repeat (20) @(negedge clk);
		chk({7'h00, link.irq}, 8'h00);
		chk({5'h00, sh}, 8'h00);
		@(posedge clk);
		recover_req <= 1'b1;
		@(posedge clk);
		recover_req <= 1'b0;
		settle_run();
		chk({5'h00, sh}, 8'h07);
	endtask
	task automatic step(input logic [2:0] ls, input logic [2:0] hs_n, input logic en);
		@(posedge clk);
		solo.phase_low_side_in <= ls;
		solo.phase_high_side_in_n <= hs_n;
		solo.gate_enable_two <= en;
		repeat (10) @(negedge clk);
	endtask
	// misordered and proper edges on the second driver
	task automatic t_solo;
		@(posedge clk);
		solo.gate_enable_one <= 1'b1;
		step(3'h0, 3'h7, 1'b1);
		repeat (50) @(negedge clk);
		step(3'h0, 3'h0, 1'b1);
		chk({5'h00, hi2}, 8'h00);
		step(3'h0, 3'h7, 1'b1);
		step(3'h7, 3'h7, 1'b1);
		chk({2'h0, sh2, lo2}, 8'h3f);
		step(3'h0, 3'h7, 1'b1);
		step(3'h0, 3'h0, 1'b1);
		chk({5'h00, hi2}, 8'h07);
		step(3'h0, 3'h7, 1'b1);
		chk({2'h0, sh2, hi2}, 8'h38);
		step(3'h0, 3'h7, 1'b0);
		chk({2'h0, sh2, lo2}, 8'h00);
		step(3'h7, 3'h7, 1'b0);
		step(3'h7, 3'h7, 1'b1);
		chk({2'h0, sh2, lo2}, 8'h00);
	endtask
	task automatic conclude;
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// watchdog well beyond the expected run
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		conclude();
	end
	initial begin
		{rstn, init_req, recover_req, fault_evt} = 11'h000;
		{ce, pump_cfg, mask_value, dead_value} = 14'h3202;
		{mode_value, ls_req, hs_n_req} = 11'h007;
		{solo.gate_enable_one, solo.gate_enable_two, solo.sclk, solo.mosi, solo.cs_n} = 5'h01;
		{solo.phase_low_side_in, solo.phase_high_side_in_n} = 6'h07;
		num_errors = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		await(0);
		repeat (4) @(negedge clk);
		chk({6'h00, pump_run, ready}, 8'h03);
		t_init(5'h01);
		t_init(5'h06);
		t_fault(8'h04, 5'h01);
		t_mask();
		t_solo();
		conclude();
	end
endmodule
`default_nettype wire

// >>> gdil_ctl_end.sv
// gate drive init lockout: controller end running init, recovery and irq service
`include "gdil_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module gdil_ctl_end #(
	parameter int PU_CYCLES = `GDIL_CYC(`GDIL_T_PU_NS),
	parameter int SCLK_HALF = `GDIL_SCLK_HALF,
	parameter bit TIED = 1'b0,
	parameter bit USE_CAL = 1'b0
) (
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic ce, // clock enable
	gdil_if.ctl bus, // pins to the driver
	input wire logic init_req, // full init pulse
	input wire logic recover_req, // recovery pulse
	input wire logic [7:0] mask_value, // 1 = source masked
	input wire logic [4:0] mode_value, // mode bits
	input wire logic [3:0] dead_value, // deadtime steps
	input wire logic [2:0] phase_ls_req, // run-time low-side level
	input wire logic [2:0] phase_hs_n_req, // run-time high-side level, low on
	output logic running, // normal operation
	output logic idle, // waiting for a request
	output logic [7:0] stat_one, // status word one
	output logic [7:0] stat_two, // status word two
	output logic stat_valid // status pair captured, pulse
);
	gdil_pkg::gdil_host_t h_reg; // all controller state
	gdil_pkg::gdil_host_t h_next; // next controller state
	logic [1:0] in_lv; // filtered miso and irq
	logic is_spi; // state sends a byte
	logic spi_done; // byte finished this cycle
	logic [7:0] cmd; // byte for this state
	logic [15:0] tgt; // wait length of this state
	gdil_pkg::gdil_hst_t nxt; // following state

	gdil_pin_sync #(.W(2)) gdil_pin_sync_i (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.pin({bus.irq, bus.miso_line}),
		.lvl(in_lv),
		.rise(),
		.fall()
	);

	// sequencing: a table per state, then one engine for bytes and waits
	always_comb begin
		h_next = h_reg;
		h_next.sval = 1'b0;
		is_spi = 1'b0;
		spi_done = 1'b0;
		cmd = 8'h00;
		tgt = 16'(`GDIL_GAP_CYC);
		nxt = h_reg.st;
		case (h_reg.st)
			gdil_pkg::H_CLR0: begin
				// enables low and all outputs off before clearing
				h_next.en = 1'b0;
				h_next.ls = 3'h0;
				h_next.hs_n = 3'h7;
				is_spi = 1'b1;
				cmd = {`GDIL_OP_CLR0, 4'hf};
				nxt = gdil_pkg::H_CLR1;
			end
			gdil_pkg::H_CLR1: begin
				is_spi = 1'b1;
				cmd = {`GDIL_OP_CLR1, 4'hf};
				nxt = h_reg.full ? gdil_pkg::H_MASK0 : gdil_pkg::H_EN;
			end
			gdil_pkg::H_MASK0: begin
				is_spi = 1'b1;
				cmd = {`GDIL_OP_MASK_LO, mask_value[3:0]};
				nxt = gdil_pkg::H_MASK1;
			end
			gdil_pkg::H_MASK1: begin
				is_spi = 1'b1;
				cmd = {`GDIL_OP_MASK_HI, mask_value[7:4]};
				nxt = gdil_pkg::H_DEAD;
			end
			gdil_pkg::H_DEAD: begin
				is_spi = 1'b1;
				cmd = USE_CAL ? {`GDIL_OP_CAL, 4'h0} : {`GDIL_OP_DEAD, dead_value};
				nxt = gdil_pkg::H_MODE;
			end
			gdil_pkg::H_MODE: begin
				is_spi = 1'b1;
				cmd = {`GDIL_MODE_CODE, mode_value, 1'b1};
				nxt = gdil_pkg::H_EN;
			end
			gdil_pkg::H_EN: begin
				h_next.en = 1'b1;
				tgt = 16'(`GDIL_CYC(`GDIL_T_EN_LS_NS));
				nxt = gdil_pkg::H_LS_HI;
			end
			gdil_pkg::H_LS_HI: begin
				// short pulse is enough after a fault or standby
				h_next.ls = 3'h7;
				tgt = h_reg.full ? 16'(`GDIL_CYC(`GDIL_T_LS_ON_NS))
					: 16'(`GDIL_CYC(`GDIL_T_LS_RCV_NS));
				nxt = gdil_pkg::H_LS_LO;
			end
			gdil_pkg::H_LS_LO: begin
				h_next.ls = 3'h0;
				nxt = gdil_pkg::H_HS_LO;
			end
			gdil_pkg::H_HS_LO: begin
				// all three together keep the motor still
				h_next.hs_n = 3'h0;
				tgt = 16'(dead_value * `GDIL_CYC(`GDIL_T_DT_STEP_NS))
					+ 16'(`GDIL_CYC(`GDIL_T_HS_ADD_NS));
				nxt = gdil_pkg::H_HS_HI;
			end
			gdil_pkg::H_HS_HI: begin
				h_next.hs_n = 3'h7;
				// tied pins go high together, the combined off level
				h_next.ls = TIED ? 3'h7 : 3'h0;
				nxt = gdil_pkg::H_RUN;
			end
			gdil_pkg::H_IRQ0: begin
				is_spi = 1'b1;
				cmd = {`GDIL_OP_STATUS_READ_CMD_FIRST, 4'h0};
				nxt = gdil_pkg::H_IRQ1;
			end
			gdil_pkg::H_IRQ1: begin
				is_spi = 1'b1;
				cmd = {`GDIL_OP_STATUS_READ_CMD_SECOND, 4'h0};
				nxt = gdil_pkg::H_CLR0;
			end
			default: begin
				// power-up, idle and run handled below
			end
		endcase
		// byte engine: mode 0, eight bits, half an sclk period gap after select
		if (is_spi) begin
			if (!h_reg.sp_act) begin
				h_next.sp_act = 1'b1;
				h_next.tx = cmd;
				h_next.cs_n = 1'b0;
				h_next.ecnt = 5'h00;
				h_next.div = 8'h00;
			end else if (h_reg.div != 8'(SCLK_HALF - 1)) begin
				h_next.div = h_reg.div + 8'h01;
			end else begin
				h_next.div = 8'h00;
				h_next.ecnt = h_reg.ecnt + 5'h01;
				if (h_reg.ecnt < 5'h10) begin
					h_next.sclk = ~h_reg.ecnt[0];
					if (!h_reg.ecnt[0]) begin
						h_next.rx = {h_reg.rx[6:0], in_lv[0]};
					end else begin
						h_next.tx = {h_reg.tx[6:0], 1'b0};
					end
				end else if (h_reg.ecnt == 5'h10) begin
					h_next.cs_n = 1'b1;
				end else begin
					h_next.sp_act = 1'b0;
					spi_done = 1'b1;
				end
			end
			if (spi_done) begin
				h_next.st = nxt;
				// each answer belongs to the previous byte sent
				if (h_reg.st == gdil_pkg::H_IRQ1) begin
					h_next.s1 = h_reg.rx;
				end
				if (h_reg.st == gdil_pkg::H_CLR0 && h_reg.irqp) begin
					h_next.s2 = h_reg.rx;
					h_next.sval = 1'b1;
				end
			end
		end else if (h_reg.st == gdil_pkg::H_PWR) begin
			// let the driver supplies settle before any byte
			if (h_reg.pu_cnt == 20'(PU_CYCLES)) begin
				h_next.st = gdil_pkg::H_IDLE;
			end else begin
				h_next.pu_cnt = h_reg.pu_cnt + 20'h0_0001;
			end
		end else if (h_reg.st == gdil_pkg::H_IDLE || h_reg.st == gdil_pkg::H_RUN) begin
			if (h_reg.st == gdil_pkg::H_RUN) begin
				h_next.ls = phase_ls_req;
				h_next.hs_n = phase_hs_n_req;
			end
			// requests beat the interrupt; irq only seen while running
			if (init_req || recover_req) begin
				h_next.full = init_req;
				h_next.irqp = 1'b0;
				h_next.st = gdil_pkg::H_CLR0;
			end else if (h_reg.st == gdil_pkg::H_RUN && in_lv[1]) begin
				h_next.full = 1'b0;
				h_next.irqp = 1'b1;
				h_next.st = gdil_pkg::H_IRQ0;
			end
		end else if (h_reg.wcnt >= tgt) begin
			h_next.wcnt = 16'h0000;
			h_next.st = nxt;
		end else begin
			h_next.wcnt = h_reg.wcnt + 16'h0001;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			h_reg <= '0;
			h_reg.st <= gdil_pkg::H_PWR;
			h_reg.cs_n <= 1'b1;
			h_reg.hs_n <= 3'h7;
		end else if (ce) begin
			h_reg <= h_next;
		end
	end

	assign bus.gate_enable_one = h_reg.en;
	assign bus.gate_enable_two = h_reg.en;
	assign bus.phase_low_side_in = h_reg.ls;
	assign bus.phase_high_side_in_n = TIED ? h_reg.ls : h_reg.hs_n;
	assign bus.sclk = h_reg.sclk;
	assign bus.cs_n = h_reg.cs_n;
	assign bus.mosi = h_reg.tx[7];
	assign running = (h_reg.st == gdil_pkg::H_RUN);
	assign idle = (h_reg.st == gdil_pkg::H_IDLE);
	assign stat_one = h_reg.s1;
	assign stat_two = h_reg.s2;
	assign stat_valid = h_reg.sval;
endmodule
`default_nettype wire

// >>> gdil_defs.svh
// gate drive init lockout: timing counts, command codes and reset values
//Contract
// - standby or fault drives every gate low
// - high side stays locked until valid init
// - recovery low-side pulse may be 100 ns
// - clear interrupts before raising the enables
// - low-side outputs enabled only with both enables
// - low-side high 100 ns re-arms high side
// - high side low for deadtime plus 100 ns
// - high sides toggle together, recirculation, no current
// - after high toggle, gate shorted, input control back
// - phase inputs edge sensitive, low rise releases
// - early high edge keeps that gate locked out
// - only low rise after enables, normal mode, counts
// - wait 280 ns from enables to low edge
// - phase inputs separate or tied as one
// - after reset, settle supplies before taking commands
// - init clears status with both clear commands
// - mask command 0010/0011 suppresses masked sources
// - set zero deadtime or calibrate before enabling; H_DEAD sends dead_value unless USE_CAL
// - mode command with lock bit blocks changes
// - fixed output init order with 1.0 us wait
// - on interrupt read status, then clear fault
// - command answer returns in the following transfer
`ifndef GDIL_DEFS_SVH
`define GDIL_DEFS_SVH
`define GDIL_CLK_NS 5
`define GDIL_CYC(ns) (((ns) + `GDIL_CLK_NS - 1) / `GDIL_CLK_NS)
`define GDIL_T_PU_NS 2000000
`define GDIL_T_EN_LS_NS 280
`define GDIL_T_LS_ON_NS 1000
`define GDIL_T_LS_RCV_NS 100
`define GDIL_T_HS_ADD_NS 100
`define GDIL_T_DT_STEP_NS 50
`define GDIL_GAP_CYC 4
`define GDIL_SCLK_HALF 10
`define GDIL_OP_STATUS_READ_CMD_FIRST 4'h0
`define GDIL_OP_STATUS_READ_CMD_SECOND 4'h1
`define GDIL_OP_MASK_LO 4'h2
`define GDIL_OP_MASK_HI 4'h3
`define GDIL_OP_CLR0 4'h8
`define GDIL_OP_CLR1 4'h9
`define GDIL_OP_DEAD 4'hc
`define GDIL_OP_CAL 4'hd
`define GDIL_MODE_POS 7:6
`define GDIL_MODE_CODE 2'h1
`define GDIL_MASK_RST 8'h00
`define GDIL_RESP_RST 8'h00
`endif

// >>> gdil_dev_end.sv
// gate drive init lockout: driver end with lockout, edge checks and serial port
`include "gdil_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module gdil_dev_end #(
	parameter int PU_CYCLES = `GDIL_CYC(`GDIL_T_PU_NS)
) (
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic ce, // clock enable
	gdil_if.dev bus, // pins to the controller
	input wire logic [7:0] fault_evt, // fault event pulses
	input wire logic pump_cfg, // charge pump wanted
	output logic [2:0] high_gate_output, // high-side gate on
	output logic [2:0] low_gate_output, // low-side gate on
	output logic [2:0] high_gate_short, // high gate tied to source
	output logic pump_run, // charge pump running
	output logic ready // supplies settled
);
	gdil_pkg::gdil_dev_t d_reg; // all driver state
	gdil_pkg::gdil_dev_t d_next; // next driver state
	logic [10:0] lv; // filtered pin levels
	logic [10:0] rs; // rising edges
	logic [10:0] fl; // falling edges
	logic pwr_ok; // settle time over
	logic normal; // both enables high, powered
	logic shut; // standby or latched fault
	logic [7:0] clr; // status bits cleared this cycle
	logic [7:0] status_word_one; // latched faults
	logic [7:0] status_word_two; // lock and mode view
	logic [7:0] status_word_three; // deadtime view
	logic [3:0] op; // received opcode

	// pin order: en1, en2, low x3, high_n x3, sclk, cs_n, mosi
	gdil_pin_sync #(.W(11)) gdil_pin_sync_i (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.pin({bus.mosi, bus.cs_n, bus.sclk, bus.phase_high_side_in_n,
			bus.phase_low_side_in, bus.gate_enable_two, bus.gate_enable_one}),
		.lvl(lv),
		.rise(rs),
		.fall(fl)
	);

	assign pwr_ok = (d_reg.pu_cnt == 20'(PU_CYCLES));
	assign normal = lv[0] & lv[1] & pwr_ok;
	assign shut = ~normal | (|d_reg.status);
	assign op = d_reg.rx[7:4];
	assign status_word_one = d_reg.status;
	assign status_word_two = {d_reg.locked, d_reg.mode, normal, |d_reg.sh};
	assign status_word_three = {d_reg.dead, d_reg.cal, 3'h0};

	// one next-state process: power-up, serial port, commands, phases
	always_comb begin
		d_next = d_reg;
		clr = 8'h00;
		// charge pump runs from reset release when configured
		d_next.pump = pump_cfg;
		// count out the settle time; commands wait for it
		if (!pwr_ok) begin
			d_next.pu_cnt = d_reg.pu_cnt + 20'h0_0001;
		end
		// select falls: preload the answer of the previous command
		if (fl[9]) begin
			d_next.bitcnt = 4'h0;
			d_next.tx = d_reg.resp;
		end else if (!lv[9]) begin
			// sample on rising clock
			if (rs[8]) begin
				d_next.rx = {d_reg.rx[6:0], lv[10]};
				if (d_reg.bitcnt != 4'hf) begin
					d_next.bitcnt = d_reg.bitcnt + 4'h1;
				end
			end
			// shift out on falling clock
			if (fl[8]) begin
				d_next.tx = {d_reg.tx[6:0], 1'b0};
			end
		end
		// select rises: act on a whole byte only, once powered up
		if (rs[9] && d_reg.bitcnt == 4'h8 && pwr_ok) begin
			// answer is stored now, shifted out next frame
			d_next.resp = status_word_three;
			if (d_reg.rx[`GDIL_MODE_POS] == `GDIL_MODE_CODE) begin
				// a set lock bit freezes mode for good
				if (!d_reg.locked) begin
					d_next.mode = d_reg.rx[5:1];
					d_next.locked = d_reg.rx[0];
				end
			end else begin
				case (op)
					`GDIL_OP_STATUS_READ_CMD_FIRST: begin
						d_next.resp = status_word_one;
					end
					`GDIL_OP_STATUS_READ_CMD_SECOND: begin
						d_next.resp = status_word_two;
					end
					`GDIL_OP_MASK_LO: begin
						d_next.mask[3:0] = d_reg.rx[3:0];
					end
					`GDIL_OP_MASK_HI: begin
						d_next.mask[7:4] = d_reg.rx[3:0];
					end
					`GDIL_OP_CLR0: begin
						clr[3:0] = d_reg.rx[3:0];
					end
					`GDIL_OP_CLR1: begin
						clr[7:4] = d_reg.rx[3:0];
					end
					`GDIL_OP_DEAD: begin
						// code zero gives zero deadtime
						d_next.dead = d_reg.rx[3:0];
						d_next.cal = 1'b0;
					end
					`GDIL_OP_CAL: begin
						d_next.cal = 1'b1;
					end
					default: begin
						// unknown opcodes are ignored
					end
				endcase
			end
		end
		// new faults beat a clear in the same cycle
		d_next.status = (d_reg.status & ~clr) | fault_evt;
		// per phase lockout and edge-driven gates
		for (int i = 0; i < 3; i++) begin
			if (shut) begin
				// all gates low, high side relocked
				d_next.lo[i] = 1'b0;
				d_next.hi[i] = 1'b0;
				d_next.sh[i] = 1'b0;
				d_next.ph[i] = gdil_pkg::PH_LOCK;
			end else begin
				// low side follows its edges, never its level
				if (d_reg.ph[i] != gdil_pkg::PH_HSON) begin
					if (rs[2+i]) begin
						d_next.lo[i] = 1'b1;
					end else if (fl[2+i]) begin
						d_next.lo[i] = 1'b0;
					end
				end
				case (d_reg.ph[i])
					gdil_pkg::PH_LOCK: begin
						// high edges here are dropped for good
						d_next.hi[i] = 1'b0;
						if (rs[2+i]) begin
							d_next.ph[i] = gdil_pkg::PH_ARMED;
							d_next.sh[i] = 1'b1;
						end
					end
					gdil_pkg::PH_ARMED: begin
						// high turn-on taken only with low side off
						if (fl[5+i] && !d_next.lo[i]) begin
							d_next.hi[i] = 1'b1;
							d_next.sh[i] = 1'b0;
							d_next.ph[i] = gdil_pkg::PH_HSON;
						end
					end
					gdil_pkg::PH_HSON: begin
						// off edge finishes init, gate back on source
						if (rs[5+i]) begin
							d_next.hi[i] = 1'b0;
							d_next.sh[i] = 1'b1;
							d_next.ph[i] = gdil_pkg::PH_RUN;
						end
					end
					gdil_pkg::PH_RUN: begin
						// normal edge control with shoot-through guard
						if (fl[5+i] && !d_next.lo[i]) begin
							d_next.hi[i] = 1'b1;
							d_next.sh[i] = 1'b0;
						end else if (rs[5+i] || d_next.lo[i]) begin
							d_next.hi[i] = 1'b0;
							d_next.sh[i] = 1'b1;
						end
					end
					default: begin
						d_next.ph[i] = gdil_pkg::PH_LOCK;
					end
				endcase
			end
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			d_reg <= '0;
			d_reg.mask <= `GDIL_MASK_RST;
			d_reg.resp <= `GDIL_RESP_RST;
		end else if (ce) begin
			d_reg <= d_next;
		end
	end

	assign high_gate_output = d_reg.hi;
	assign low_gate_output = d_reg.lo;
	assign high_gate_short = d_reg.sh;
	assign pump_run = d_reg.pump;
	assign ready = pwr_ok;
	assign bus.miso = d_reg.tx[7];
	// release the data line when not selected; select level is filtered
	assign bus.miso_oe = ~lv[9];
	// masked sources never reach the interrupt pin
	assign bus.irq = |(d_reg.status & ~d_reg.mask);
endmodule
`default_nettype wire

// >>> gdil_if.sv
// gate drive init lockout: pins between controller and driver
`timescale 1ns/10ps
`default_nettype none
interface gdil_if;
	logic gate_enable_one; // first enable
	logic gate_enable_two; // second enable
	logic [2:0] phase_low_side_in; // low-side inputs, high = on
	logic [2:0] phase_high_side_in_n; // high-side inputs, low = on
	logic sclk; // serial clock
	logic cs_n; // serial select, active low
	logic mosi; // controller to driver data
	logic miso; // driver data out
	logic miso_oe; // driver drives miso
	logic miso_line; // resolved miso wire
	logic irq; // interrupt, active high
	// released line floats high through a pull-up
	assign miso_line = miso_oe ? miso : 1'b1;
	modport dev (input gate_enable_one, gate_enable_two, phase_low_side_in,
		phase_high_side_in_n, sclk, cs_n, mosi, output miso, miso_oe, irq);
	modport ctl (output gate_enable_one, gate_enable_two, phase_low_side_in,
		phase_high_side_in_n, sclk, cs_n, mosi, input miso_line, irq);
endinterface
`default_nettype wire

// >>> gdil_link_monitor.sv
// gate drive init lockout: pin-level checks on the controller-driver link
`timescale 1ns/10ps
`default_nettype none
module gdil_link_monitor #(
	parameter int DT_CYC = 0
) (
	input wire logic clk, // system clock
	input wire logic rstn, // sync reset, active low
	input wire logic gate_enable_one, // first enable
	input wire logic gate_enable_two, // second enable
	input wire logic [2:0] phase_low_side_in, // low-side inputs
	input wire logic [2:0] phase_high_side_in_n, // high-side inputs, low on
	input wire logic sclk, // serial clock
	input wire logic cs_n, // serial select
	input wire logic irq // driver interrupt
);
	logic [7:0] en_cnt; // cycles with both enables high
	logic [7:0] ls_cnt; // cycles with all low sides on
	logic [7:0] hs_cnt; // cycles with all high sides on
	// saturating run lengths, so a long run never wraps to a false short one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_cnt <= 8'h00;
			ls_cnt <= 8'h00;
			hs_cnt <= 8'h00;
		end else begin
			en_cnt <= (gate_enable_one && gate_enable_two) ? en_cnt + {7'h00, ~&en_cnt} : 8'h00;
			ls_cnt <= (phase_low_side_in == 3'h7) ? ls_cnt + {7'h00, ~&ls_cnt} : 8'h00;
			hs_cnt <= (phase_high_side_in_n == 3'h0) ? hs_cnt + {7'h00, ~&hs_cnt} : 8'h00;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_ls_after_enable: assert property ($rose(phase_low_side_in[0]) |-> en_cnt >= 8'h38)
		else $error("low side rose too soon after enables");
	a_ls_on_length: assert property ($fell(phase_low_side_in[0]) |-> ls_cnt >= 8'h14)
		else $error("low side pulse too short");
	a_hs_on_length: assert property ($rose(phase_high_side_in_n[0]) |-> hs_cnt >= DT_CYC + 8'h14)
		else $error("high side pulse shorter than deadtime plus margin");
	a_hs_together: assert property ($fell(phase_high_side_in_n[0]) |-> phase_high_side_in_n == 3'h0)
		else $error("high sides not toggled together");
	a_ls_hs_off: assert property ($rose(phase_low_side_in[0]) |-> phase_high_side_in_n == 3'h7)
		else $error("low side on while high side commanded on");
	a_no_cross: assert property (!(|(phase_low_side_in & ~phase_high_side_in_n)))
		else $error("both sides of a phase commanded on");
	a_clear_first: assert property ($rose(gate_enable_one) |-> !irq)
		else $error("enables raised with an interrupt pending");
	a_enables_pair: assert property (gate_enable_one == gate_enable_two)
		else $error("enables differ");
	a_sclk_framed: assert property ($rose(sclk) |-> !cs_n)
		else $error("serial clock outside a frame");
	// main traffic seen at all
	cover property ($rose(gate_enable_one));
	cover property ($fell(cs_n));
	cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> gdil_pin_sync.sv
// gate drive init lockout: three-flop pin filter with edge pulses
`timescale 1ns/10ps
`default_nettype none
module gdil_pin_sync #(
	parameter int W = 11
) (
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic ce, // clock enable
	input wire logic [W-1:0] pin, // asynchronous pins
	output logic [W-1:0] lvl, // accepted level
	output logic [W-1:0] rise, // one-cycle rising pulse
	output logic [W-1:0] fall // one-cycle falling pulse
);
	typedef struct packed {
		logic [W-1:0] s1; logic [W-1:0] s2; logic [W-1:0] s3; logic [W-1:0] lv;
		logic [1:0] warm;
	} gdil_sync_t;
	gdil_sync_t q_reg; // all filter state
	gdil_sync_t q_next; // next filter state
	// s1 feeds only s2; a change counts once s2 and s3 agree
	always_comb begin
		q_next = q_reg;
		q_next.s1 = pin;
		q_next.s2 = q_reg.s1;
		q_next.s3 = q_reg.s2;
		if (q_reg.warm != 2'h3) begin
			// priming after reset: idle-high pins must not look like rising edges
			q_next.warm = q_reg.warm + 2'h1;
			q_next.lv = q_reg.s2;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (q_reg.s2[i] == q_reg.s3[i]) begin
					q_next.lv[i] = q_reg.s3[i];
				end
			end
		end
	end
	// register, frozen while ce is low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			q_reg <= '0;
		end else if (ce) begin
			q_reg <= q_next;
		end
	end
	assign lvl = q_reg.lv;
	// edge pulses per bit, one cycle ahead of the level update
	for (genvar i = 0; i < W; i++) begin : g_edge
		assign rise[i] = (q_reg.warm == 2'h3) & (q_reg.s2[i] == q_reg.s3[i]) & q_reg.s3[i]
			& ~q_reg.lv[i];
		assign fall[i] = (q_reg.warm == 2'h3) & (q_reg.s2[i] == q_reg.s3[i]) & ~q_reg.s3[i]
			& q_reg.lv[i];
	end
endmodule
`default_nettype wire

// >>> gdil_pkg.sv
// gate drive init lockout: shared state types
package gdil_pkg;
	typedef enum logic [1:0] {
		PH_LOCK = 2'b00,
		PH_ARMED = 2'b01,
		PH_HSON = 2'b10,
		PH_RUN = 2'b11
	} gdil_ph_t;
	typedef enum logic [3:0] {
		H_PWR = 4'b0000, H_IDLE = 4'b0001, H_CLR0 = 4'b0010, H_CLR1 = 4'b0011,
		H_MASK0 = 4'b0100, H_MASK1 = 4'b0101, H_DEAD = 4'b0110, H_MODE = 4'b0111,
		H_EN = 4'b1000, H_LS_HI = 4'b1001, H_LS_LO = 4'b1010, H_HS_LO = 4'b1011,
		H_HS_HI = 4'b1100, H_RUN = 4'b1101, H_IRQ0 = 4'b1110, H_IRQ1 = 4'b1111
	} gdil_hst_t;
	typedef struct packed {
		logic [19:0] pu_cnt; logic pump; logic [3:0] bitcnt;
		logic [7:0] rx; logic [7:0] tx; logic [7:0] resp;
		logic [7:0] status; logic [7:0] mask; logic [4:0] mode; logic locked;
		logic [3:0] dead; logic cal;
		gdil_ph_t [2:0] ph; logic [2:0] lo; logic [2:0] hi; logic [2:0] sh;
	} gdil_dev_t;
	typedef struct packed {
		gdil_hst_t st; logic full; logic irqp; logic [19:0] pu_cnt; logic [15:0] wcnt;
		logic en; logic [2:0] ls; logic [2:0] hs_n;
		logic sp_act; logic [4:0] ecnt; logic [7:0] div; logic sclk; logic cs_n;
		logic [7:0] tx; logic [7:0] rx; logic [7:0] s1; logic [7:0] s2; logic sval;
	} gdil_host_t;
endpackage
